// >>> bench/host_model.sv
// Host-side model: serial register writes, message ends, bursts
`timescale 1ns/1ps
module host_model (
  input wire logic clock_i,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic msg_end_o,
  output logic burst_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    msg_end_o = 1'b0;
    burst_o = 1'b0;
  end
  // One byte per strobe; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_o <= a;
  endtask
  // Stop condition after the last byte of a message
  task automatic msg();
    @(posedge clock_i);
    msg_end_o <= 1'b1;
    @(posedge clock_i);
    msg_end_o <= 1'b0;
  endtask
  // Burst flag spans the whole auto-increment message
  task automatic hold(input logic b);
    @(posedge clock_i);
    burst_o <= b;
  endtask
endmodule

// >>> bench/tb.sv
// Testbench: host model, field events, queued output checks
`timescale 1ns/1ps
module tb;
  import tpu_pkg::*;
  logic clock_i, rstn_i, gimm, dimm;
  logic [3:0] ev;
  wire logic wr, me, bst, odd;
  wire logic [7:0] addr, wdata, rdata, gain, div, su0;
  wire logic [15:0] fine, coarse, hof, vof, lln, fln;
  wire logic [6:0] pend;
  logic [15:0] o [11];
  logic [15:0] q [$];
  logic [15:0] c, e;
  logic [7:0] g;
  logic [7:0] md [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
  logic [3:0] nb [4] = '{4'h0, 4'h0, 4'h3, 4'h1};
  int sel, seed, fails = 0, checks = 0;
  event look;
  host_model h (.clock_i(clock_i), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata), .msg_end_o(me), .burst_o(bst));
  timed_parameter_update dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .msg_end_i(me), .burst_active_i(bst), .field_start_i(ev[0]),
    .sav_first_dark_i(ev[1]), .sav_first_visible_i(ev[2]),
    .sav_eof_i(ev[3]), .gain_immediate_i(gimm),
    .clkdiv_immediate_i(dimm), .fine_exposure_o(fine),
    .coarse_exposure_o(coarse), .gain_o(gain), .clkdiv_o(div),
    .hoffset_o(hof), .voffset_o(vof), .primary_setup_o(su0), .secondary_setup_o(),
    .rdfmt_o(), .line_length_o(lln), .field_length_o(fln),
    .odd_field_o(odd), .pending_o(pend));
  // Observable outputs, picked by index at each check
  always_comb o = '{16'(rdata), 16'(pend), coarse, 16'(gain), 16'(div),
    fine, hof, vof, lln, 16'(su0), fln};
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Note the expectation; the monitor compares once outputs settle
  task automatic chk(input int s, input logic [15:0] x);
    q.push_back(x);
    sel = s;
    -> look;
    #2;
  endtask
  initial forever begin
    @(look);
    #1;
    e = q.pop_front();
    checks++;
    if (o[sel] !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, o[sel], e);
      fails++;
    end
  end
  // One-cycle timing event: 0 field, 1 dark, 2 visible, 3 end of frame
  task automatic pulse(input int i);
    @(posedge clock_i);
    ev <= 4'(1 << i);
    @(posedge clock_i);
    ev <= 4'h0;
  endtask
  // Run takes well under 1000 cycles
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  initial begin
    rstn_i = 1'b0;
    ev = 4'h0;
    gimm = 1'b0;
    dimm = 1'b0;
    seed = 40;
    c = 16'($random(seed));
    g = 8'($random(seed)) | 8'h01;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    chk(3, 16'h00f0);
    chk(1, 16'h0000);
    h.wr(ADDR_COARSE_HI, c[15:8]);
    h.wr(ADDR_COARSE_LO, c[7:0]);
    h.wr(ADDR_STATUS, 8'hff);
    h.rd(ADDR_STATUS);
    chk(0, 16'h0002);
    pulse(1);
    chk(2, 16'h0000);
    pulse(0);
    pulse(1);
    chk(2, c);
    chk(1, 16'h0000);
    h.wr(ADDR_VOFS_HI, 8'h12);
    h.wr(ADDR_VOFS_LO, 8'h34);
    pulse(2);
    chk(7, 16'h1234);
    h.hold(1'b1);
    h.wr(ADDR_GAIN, g);
    pulse(3);
    chk(3, 16'h00f0);
    h.hold(1'b0);
    h.wr(ADDR_HOFS_LO, 8'h5a);
    chk(1, 16'h0018);
    pulse(3);
    chk(3, {8'h00, g});
    chk(6, 16'h005a);
    h.wr(ADDR_CLKDIV, 8'hf5);
    for (int i = 0; i < 4; i++) begin
      h.wr(ADDR_PRIMARY_SETUP, md[i]);
      h.rd(ADDR_CLKDIV);
      chk(0, {8'h00, nb[i], 4'h5});
    end
    h.wr(ADDR_LINE_LO, 8'h40);
    h.wr(ADDR_FIELD_LO, 8'h21);
    h.wr(ADDR_FINE_LO, 8'h33);
    pulse(3);
    chk(5, 16'h0000);
    chk(1, 16'h0045);
    pulse(0);
    chk(5, 16'h0033);
    chk(4, 16'h0015);
    chk(8, 16'h0040);
    chk(10, 16'h0021);
    chk(1, 16'h0000);
    @(posedge clock_i);
    gimm <= 1'b1;
    dimm <= 1'b1;
    h.wr(ADDR_GAIN, 8'h3c);
    h.wr(ADDR_FINE_LO, 8'h77);
    h.wr(ADDR_CLKDIV, 8'h09);
    h.msg();
    chk(3, 16'h003c);
    chk(4, 16'h0019);
    chk(5, 16'h0033);
    end_of_test();
  end
endmodule
bind timed_parameter_update tpu_chk u_chk (.clock_i(clock_i),
  .rstn_i(rstn_i), .wr_i(wr_i), .addr_i(addr_i), .msg_end_i(msg_end_i),
  .burst_active_i(burst_active_i), .field_start_i(field_start_i),
  .sav_first_dark_i(sav_first_dark_i),
  .sav_first_visible_i(sav_first_visible_i), .sav_eof_i(sav_eof_i),
  .clkdiv_immediate_i(clkdiv_immediate_i),
  .fine_exposure_o(fine_exposure_o),
  .coarse_exposure_o(coarse_exposure_o), .gain_o(gain_o),
  .clkdiv_o(clkdiv_o), .hoffset_o(hoffset_o),
  .odd_field_o(odd_field_o), .pending_o(pending_o));

// >>> bench/tpu_chk.sv
// Assertion checker for the timed parameter update block
`timescale 1ns/1ps
module tpu_chk
  import tpu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic msg_end_i,
  input wire logic burst_active_i,
  input wire logic field_start_i,
  input wire logic sav_first_dark_i,
  input wire logic sav_first_visible_i,
  input wire logic sav_eof_i,
  input wire logic clkdiv_immediate_i,
  input wire logic [15:0] fine_exposure_o,
  input wire logic [15:0] coarse_exposure_o,
  input wire logic [7:0] gain_o,
  input wire logic [7:0] clkdiv_o,
  input wire logic [15:0] hoffset_o,
  input wire logic odd_field_o,
  input wire logic [6:0] pending_o
);
  // Slots only count in an odd field with no burst open
  wire logic slot_open = odd_field_o && !burst_active_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Working registers move only at their own slot
  property p_coarse_pt;
    $changed(coarse_exposure_o) |-> $past(sav_first_dark_i && slot_open);
  endproperty
  a_coarse_pt: assert property (p_coarse_pt)
    else $error("coarse exposure moved off its slot");
  property p_pan_pt;
    $changed(hoffset_o) |-> $past(sav_eof_i && slot_open);
  endproperty
  a_pan_pt: assert property (p_pan_pt)
    else $error("pan moved off its slot");
  property p_fine_pt;
    $changed(fine_exposure_o) |->
      $past((sav_eof_i || field_start_i) && slot_open);
  endproperty
  a_fine_pt: assert property (p_fine_pt)
    else $error("fine exposure moved off its slot");
  // Divisor: field transition, or message end when immediate
  property p_div_pt;
    $changed(clkdiv_o) |-> $past(field_start_i && slot_open) ||
      $past(msg_end_i && clkdiv_immediate_i);
  endproperty
  a_div_pt: assert property (p_div_pt)
    else $error("divisor moved off its slot");
  property p_pend_set;
    wr_i && addr_i == ADDR_COARSE_HI |=> pending_o[PEND_COARSE];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("coarse write left flag low");
  // A racing write could legally re-set the flag, hence no write
  property p_pend_clr;
    pending_o[PEND_TILT] && sav_first_visible_i && slot_open && !wr_i
      |=> !pending_o[PEND_TILT];
  endproperty
  a_pend_clr: assert property (p_pend_clr)
    else $error("tilt flag stuck after transfer");
  property p_parity;
    field_start_i |=> odd_field_o != $past(odd_field_o);
  endproperty
  a_parity: assert property (p_parity)
    else $error("field parity did not toggle");
  property p_burst;
    burst_active_i && !msg_end_i |=> $stable(gain_o);
  endproperty
  a_burst: assert property (p_burst)
    else $error("gain moved during a burst");
  c_coarse: cover property (sav_first_dark_i && slot_open);
  c_burst: cover property (burst_active_i && sav_eof_i && odd_field_o);
  c_imm: cover property (msg_end_i && clkdiv_immediate_i);
endmodule

// >>> src/timed_parameter_update.sv
// Shadow-to-working transfer scheduler for the timed sensor settings
`timescale 1ns/1ps
module timed_parameter_update (
  input wire logic clock_i,
  input wire logic rstn_i,
  // Serial register port, one-cycle write strobes from the I2C slave; reads decode addr_i alone
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic msg_end_i,
  input wire logic burst_active_i,
  // Field timing events, one-cycle pulses from the video timing generator
  input wire logic field_start_i,
  input wire logic sav_first_dark_i,
  input wire logic sav_first_visible_i,
  input wire logic sav_eof_i,
  // Immediate update selects
  input wire logic gain_immediate_i,
  input wire logic clkdiv_immediate_i,
  // Working registers, field parity and pending flags
  output logic [15:0] fine_exposure_o,
  output logic [15:0] coarse_exposure_o,
  output logic [7:0] gain_o,
  output logic [7:0] clkdiv_o,
  output logic [15:0] hoffset_o,
  output logic [15:0] voffset_o,
  output logic [7:0] primary_setup_o,
  output logic [7:0] secondary_setup_o,
  output logic [7:0] rdfmt_o,
  output logic [15:0] line_length_o,
  output logic [15:0] field_length_o,
  output logic odd_field_o,
  output logic [6:0] pending_o
);
  import tpu_pkg::*;

  // Shadow copies written by the host
  logic [7:0] sh_fine_hi_r, sh_fine_lo_r, sh_coarse_hi_r, sh_coarse_lo_r;
  logic [7:0] sh_gain_r, sh_clkdiv_r, sh_primary_setup_r, sh_secondary_setup_r;
  logic [7:0] sh_fg_r, sh_rdfmt_r, sh_opfmt_r, sh_opsel_r;
  logic [7:0] sh_pix_hi_r, sh_pix_lo_r, sh_line_hi_r, sh_line_lo_r;
  logic [7:0] sh_hofs_hi_r, sh_hofs_lo_r, sh_vofs_hi_r, sh_vofs_lo_r;
  logic [7:0] sh_field_hi_r, sh_field_lo_r;
  logic [6:0] pend_r;
  logic [6:0] set_pend;
  logic [6:0] clr_pend;
  logic line_pend_r;
  logic odd_r;
  logic gain_imm_req_r, div_imm_req_r;
  logic [3:0] div_hi;
  logic [1:0] wmode;
  logic odd_to_even, fine_at_eof, fine_at_field;
  logic do_coarse, do_tilt, do_gainpan, do_field;

  // Upper divisor nibble follows the shadow video mode
  assign wmode = wdata_i[PRIMARY_SETUP_MODE_MSB:PRIMARY_SETUP_MODE_LSB];
  always_comb begin
    case (wmode)
      MODE_CIF: div_hi = DIV_HI_CIF;
      MODE_QCIF: div_hi = DIV_HI_QCIF;
      default: div_hi = DIV_HI_PALNTSC;
    endcase
  end

  // Shadow writes, accepted at any point in the field
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sh_fine_hi_r <= RST_ZERO;
      sh_fine_lo_r <= RST_ZERO;
      sh_coarse_hi_r <= RST_ZERO;
      sh_coarse_lo_r <= RST_ZERO;
      sh_gain_r <= RST_GAIN;
      sh_clkdiv_r <= RST_CLKDIV;
      sh_primary_setup_r <= RST_ZERO;
      sh_secondary_setup_r <= RST_ZERO;
      sh_fg_r <= RST_ZERO;
      sh_rdfmt_r <= RST_ZERO;
      sh_opfmt_r <= RST_ZERO;
      sh_opsel_r <= RST_ZERO;
      sh_pix_hi_r <= RST_ZERO;
      sh_pix_lo_r <= RST_ZERO;
      sh_line_hi_r <= RST_ZERO;
      sh_line_lo_r <= RST_ZERO;
      sh_hofs_hi_r <= RST_ZERO;
      sh_hofs_lo_r <= RST_ZERO;
      sh_vofs_hi_r <= RST_ZERO;
      sh_vofs_lo_r <= RST_ZERO;
      sh_field_hi_r <= RST_ZERO;
      sh_field_lo_r <= RST_ZERO;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_FINE_HI: sh_fine_hi_r <= wdata_i;
        ADDR_FINE_LO: sh_fine_lo_r <= wdata_i;
        ADDR_COARSE_HI: sh_coarse_hi_r <= wdata_i;
        ADDR_COARSE_LO: sh_coarse_lo_r <= wdata_i;
        ADDR_GAIN: sh_gain_r <= wdata_i;
        // Host reaches only the low nibble
        ADDR_CLKDIV: sh_clkdiv_r[3:0] <= wdata_i[3:0];
        ADDR_PRIMARY_SETUP: begin
          sh_primary_setup_r <= wdata_i;
          sh_clkdiv_r[7:4] <= div_hi;
        end
        ADDR_SECONDARY_SETUP: sh_secondary_setup_r <= wdata_i;
        ADDR_FGCFG: sh_fg_r <= wdata_i;
        ADDR_RDFMT: sh_rdfmt_r <= wdata_i;
        ADDR_OPFMT: sh_opfmt_r <= wdata_i;
        ADDR_OPSEL: sh_opsel_r <= wdata_i;
        ADDR_PIXOFS_HI: sh_pix_hi_r <= wdata_i;
        ADDR_PIXOFS_LO: sh_pix_lo_r <= wdata_i;
        ADDR_LINE_HI: sh_line_hi_r <= wdata_i;
        ADDR_LINE_LO: sh_line_lo_r <= wdata_i;
        ADDR_HOFS_HI: sh_hofs_hi_r <= wdata_i;
        ADDR_HOFS_LO: sh_hofs_lo_r <= wdata_i;
        ADDR_VOFS_HI: sh_vofs_hi_r <= wdata_i;
        ADDR_VOFS_LO: sh_vofs_lo_r <= wdata_i;
        ADDR_FIELD_HI: sh_field_hi_r <= wdata_i;
        ADDR_FIELD_LO: sh_field_lo_r <= wdata_i;
        default: ; // Status and unmapped writes ignored
      endcase
    end
  end

  // Which pending flags a write raises
  always_comb begin
    set_pend = 7'h00;
    if (wr_i) begin
      case (addr_i)
        ADDR_FINE_HI, ADDR_FINE_LO: set_pend[PEND_FINE] = 1'b1;
        ADDR_COARSE_HI, ADDR_COARSE_LO:
          set_pend[PEND_COARSE] = 1'b1;
        ADDR_GAIN: set_pend[PEND_GAIN] = 1'b1;
        ADDR_CLKDIV: set_pend[PEND_CLKDIV] = 1'b1;
        ADDR_HOFS_HI, ADDR_HOFS_LO: set_pend[PEND_PAN] = 1'b1;
        ADDR_VOFS_HI, ADDR_VOFS_LO: set_pend[PEND_TILT] = 1'b1;
        ADDR_PRIMARY_SETUP: begin
          set_pend[PEND_VIDEO] = 1'b1;
          if (wdata_i[PRIMARY_SETUP_SUBQCIF] != sh_primary_setup_r[PRIMARY_SETUP_SUBQCIF]) begin
            set_pend[PEND_PAN] = 1'b1;
            set_pend[PEND_TILT] = 1'b1;
          end
        end
        ADDR_SECONDARY_SETUP: begin
          set_pend[PEND_VIDEO] = 1'b1;
          if (wdata_i[SECONDARY_SETUP_HSHUFFLE] != sh_secondary_setup_r[SECONDARY_SETUP_HSHUFFLE])
            set_pend[PEND_PAN] = 1'b1;
        end
        ADDR_RDFMT: begin
          set_pend[PEND_VIDEO] = 1'b1;
          if (wdata_i[RDFMT_HMIRROR] != sh_rdfmt_r[RDFMT_HMIRROR])
            set_pend[PEND_PAN] = 1'b1;
          if (wdata_i[RDFMT_HMIRROR:RDFMT_HSHUFFLE]
              != sh_rdfmt_r[RDFMT_HMIRROR:RDFMT_HSHUFFLE])
            set_pend[PEND_TILT] = 1'b1;
        end
        ADDR_FGCFG, ADDR_OPFMT, ADDR_OPSEL, ADDR_PIXOFS_HI, ADDR_PIXOFS_LO,
        ADDR_LINE_HI, ADDR_LINE_LO, ADDR_FIELD_HI, ADDR_FIELD_LO:
          set_pend[PEND_VIDEO] = 1'b1;
        default: ;
      endcase
    end
  end

  // Field parity, toggled at every field start in every mode
  always_ff @(posedge clock_i) begin
    if (!rstn_i)
      odd_r <= 1'b0;
    else if (field_start_i)
      odd_r <= ~odd_r;
  end
  // Odd field ending: new field starting while odd
  assign odd_to_even = field_start_i && odd_r;

  // Transfer points; a burst in progress holds off every timed transfer
  assign do_coarse = sav_first_dark_i && odd_r && !burst_active_i;
  assign do_tilt = sav_first_visible_i && odd_r && !burst_active_i;
  // Gain waits for the end-of-frame slot, later in the same odd field than coarse exposure
  assign do_gainpan = sav_eof_i && odd_r && !burst_active_i;
  assign do_field = odd_to_even && !burst_active_i;
  assign fine_at_eof = do_gainpan && !line_pend_r;
  assign fine_at_field = do_field && line_pend_r;

  // Line length change tracking for the fine exposure point
  always_ff @(posedge clock_i) begin
    if (!rstn_i)
      line_pend_r <= 1'b0;
    else if (wr_i && (addr_i == ADDR_LINE_HI || addr_i == ADDR_LINE_LO))
      line_pend_r <= 1'b1;
    else if (do_field)
      line_pend_r <= 1'b0;
  end

  // Immediate requests, fired once the serial message has completed
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      gain_imm_req_r <= 1'b0;
      div_imm_req_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == ADDR_GAIN && gain_immediate_i)
        gain_imm_req_r <= 1'b1;
      else if (msg_end_i)
        gain_imm_req_r <= 1'b0;
      if (wr_i && addr_i == ADDR_CLKDIV && clkdiv_immediate_i)
        div_imm_req_r <= 1'b1;
      else if (msg_end_i)
        div_imm_req_r <= 1'b0;
    end
  end

  // Pending flags clear on their transfer
  always_comb begin
    clr_pend = 7'h00;
    clr_pend[PEND_COARSE] = do_coarse;
    clr_pend[PEND_TILT] = do_tilt;
    clr_pend[PEND_GAIN] = (do_gainpan && !gain_immediate_i) ||
                          (gain_imm_req_r && msg_end_i);
    clr_pend[PEND_PAN] = do_gainpan;
    clr_pend[PEND_FINE] = fine_at_eof || fine_at_field;
    clr_pend[PEND_CLKDIV] = (do_field && !clkdiv_immediate_i) ||
                            (div_imm_req_r && msg_end_i);
    clr_pend[PEND_VIDEO] = do_field;
  end

  // Set wins over clear so no write is lost
  always_ff @(posedge clock_i) begin
    if (!rstn_i)
      pend_r <= 7'h00;
    else
      pend_r <= (pend_r & ~clr_pend) | set_pend;
  end

  // Exposure working registers, deferred path only
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fine_exposure_o <= 16'h0000;
      coarse_exposure_o <= 16'h0000;
    end else begin
      if (do_coarse && pend_r[PEND_COARSE])
        coarse_exposure_o <= {sh_coarse_hi_r, sh_coarse_lo_r};
      if ((fine_at_eof || fine_at_field) && pend_r[PEND_FINE])
        fine_exposure_o <= {sh_fine_hi_r, sh_fine_lo_r};
    end
  end

  // Gain and divisor: timed, or immediate at message end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      gain_o <= RST_GAIN;
      clkdiv_o <= RST_CLKDIV;
    end else begin
      if (gain_imm_req_r && msg_end_i)
        gain_o <= sh_gain_r;
      else if (do_gainpan && !gain_immediate_i && pend_r[PEND_GAIN])
        gain_o <= sh_gain_r;
      if (div_imm_req_r && msg_end_i)
        clkdiv_o <= sh_clkdiv_r;
      else if (do_field && !clkdiv_immediate_i && pend_r[PEND_CLKDIV])
        clkdiv_o <= sh_clkdiv_r;
    end
  end

  // Pan and tilt working registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      hoffset_o <= 16'h0000;
      voffset_o <= 16'h0000;
    end else begin
      if (do_gainpan && pend_r[PEND_PAN])
        hoffset_o <= {sh_hofs_hi_r, sh_hofs_lo_r};
      if (do_tilt && pend_r[PEND_TILT])
        voffset_o <= {sh_vofs_hi_r, sh_vofs_lo_r};
    end
  end

  // Video timing working registers, last in the field order
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      primary_setup_o <= RST_ZERO;
      secondary_setup_o <= RST_ZERO;
      rdfmt_o <= RST_ZERO;
      line_length_o <= 16'h0000;
      field_length_o <= 16'h0000;
    end else if (do_field && pend_r[PEND_VIDEO]) begin
      primary_setup_o <= sh_primary_setup_r;
      secondary_setup_o <= sh_secondary_setup_r;
      rdfmt_o <= sh_rdfmt_r;
      line_length_o <= {sh_line_hi_r, sh_line_lo_r};
      field_length_o <= {sh_field_hi_r, sh_field_lo_r};
    end
  end

  // Read-back of shadows and the read-only status
  always_comb begin
    case (addr_i)
      ADDR_STATUS: rdata_o = {1'b0, pend_r};
      ADDR_FINE_HI: rdata_o = sh_fine_hi_r;
      ADDR_FINE_LO: rdata_o = sh_fine_lo_r;
      ADDR_COARSE_HI: rdata_o = sh_coarse_hi_r;
      ADDR_COARSE_LO: rdata_o = sh_coarse_lo_r;
      ADDR_GAIN: rdata_o = sh_gain_r;
      ADDR_CLKDIV: rdata_o = sh_clkdiv_r;
      ADDR_PRIMARY_SETUP: rdata_o = sh_primary_setup_r;
      ADDR_SECONDARY_SETUP: rdata_o = sh_secondary_setup_r;
      ADDR_FGCFG: rdata_o = sh_fg_r;
      ADDR_RDFMT: rdata_o = sh_rdfmt_r;
      ADDR_OPFMT: rdata_o = sh_opfmt_r;
      ADDR_OPSEL: rdata_o = sh_opsel_r;
      ADDR_PIXOFS_HI: rdata_o = sh_pix_hi_r;
      ADDR_PIXOFS_LO: rdata_o = sh_pix_lo_r;
      ADDR_LINE_HI: rdata_o = sh_line_hi_r;
      ADDR_LINE_LO: rdata_o = sh_line_lo_r;
      ADDR_HOFS_HI: rdata_o = sh_hofs_hi_r;
      ADDR_HOFS_LO: rdata_o = sh_hofs_lo_r;
      ADDR_VOFS_HI: rdata_o = sh_vofs_hi_r;
      ADDR_VOFS_LO: rdata_o = sh_vofs_lo_r;
      ADDR_FIELD_HI: rdata_o = sh_field_hi_r;
      ADDR_FIELD_LO: rdata_o = sh_field_lo_r;
      default: rdata_o = 8'h00;
    endcase
  end

  assign odd_field_o = odd_r;
  assign pending_o = pend_r;
endmodule

// >>> src/tpu_pkg.sv
// Package with register map, field layout and reset values of the update block
package tpu_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_PRIMARY_SETUP = 8'h10;
  localparam logic [7:0] ADDR_SECONDARY_SETUP = 8'h11;
  localparam logic [7:0] ADDR_FGCFG = 8'h14;
  localparam logic [7:0] ADDR_RDFMT = 8'h16;
  localparam logic [7:0] ADDR_OPFMT = 8'h17;
  localparam logic [7:0] ADDR_OPSEL = 8'h18;
  localparam logic [7:0] ADDR_FINE_HI = 8'h20;
  localparam logic [7:0] ADDR_FINE_LO = 8'h21;
  localparam logic [7:0] ADDR_COARSE_HI = 8'h22;
  localparam logic [7:0] ADDR_COARSE_LO = 8'h23;
  localparam logic [7:0] ADDR_GAIN = 8'h24;
  localparam logic [7:0] ADDR_CLKDIV = 8'h25;
  localparam logic [7:0] ADDR_PIXOFS_HI = 8'h2c;
  localparam logic [7:0] ADDR_PIXOFS_LO = 8'h2d;
  localparam logic [7:0] ADDR_LINE_HI = 8'h52;
  localparam logic [7:0] ADDR_LINE_LO = 8'h53;
  localparam logic [7:0] ADDR_HOFS_HI = 8'h57;
  localparam logic [7:0] ADDR_HOFS_LO = 8'h58;
  localparam logic [7:0] ADDR_VOFS_HI = 8'h59;
  localparam logic [7:0] ADDR_VOFS_LO = 8'h5a;
  localparam logic [7:0] ADDR_FIELD_HI = 8'h61;
  localparam logic [7:0] ADDR_FIELD_LO = 8'h62;
  // Pending flag bit positions in the status register
  localparam int PEND_FINE = 0;
  localparam int PEND_COARSE = 1;
  localparam int PEND_CLKDIV = 2;
  localparam int PEND_GAIN = 3;
  localparam int PEND_PAN = 4;
  localparam int PEND_TILT = 5;
  localparam int PEND_VIDEO = 6;
  // Field positions inside the setup and format registers
  localparam int PRIMARY_SETUP_MODE_LSB = 0;
  localparam int PRIMARY_SETUP_MODE_MSB = 1;
  localparam int PRIMARY_SETUP_SUBQCIF = 2;
  localparam int SECONDARY_SETUP_HSHUFFLE = 0;
  localparam int RDFMT_HSHUFFLE = 0;
  localparam int RDFMT_HMIRROR = 1;
  // Video mode codes held in the primary setup register
  localparam logic [1:0] MODE_PAL = 2'h0;
  localparam logic [1:0] MODE_NTSC = 2'h1;
  localparam logic [1:0] MODE_CIF = 2'h2;
  localparam logic [1:0] MODE_QCIF = 2'h3;
  // Divisor upper nibble per video mode
  localparam logic [3:0] DIV_HI_CIF = 4'h1;
  localparam logic [3:0] DIV_HI_QCIF = 4'h3;
  localparam logic [3:0] DIV_HI_PALNTSC = 4'h0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CLKDIV = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'hf0;
endpackage
